// *** src/tcsr_defs.svh ***
// constants of the timer control and status register
`ifndef TCSR_DEFS_SVH
`define TCSR_DEFS_SVH
// ==========================================
// register location and reset
`define TCSR_ADDR 8'h88
`define TCSR_RESET 8'h00
`define TCSR_BITADDR_HI 7:3
`define TCSR_BITSEL_LO 2:0
// ==========================================
// bit positions within the register
`define TCSR_TF_B 3'h7
`define TCSR_TR_B 3'h6
`define TCSR_TF_A 3'h5
`define TCSR_TR_A 3'h4
`define TCSR_IE_B 3'h3
`define TCSR_IT_B 3'h2
`define TCSR_IE_A 3'h1
`define TCSR_IT_A 3'h0
// ==========================================
// detector state after reset: input counted as already active
`define TCSR_PREV_RESET 1'b1
`endif

// *** src/tcsr_pkg.sv ***
// types shared by the timer control and status block
package tcsr_pkg;
  // ==========================================
  // register byte
  typedef logic [7:0] tcsr_byte_t;
  // ==========================================
  // trigger type of an external interrupt input
  typedef enum logic {
    TCSR_LEVEL = 1'b0,
    TCSR_EDGE = 1'b1
  } tcsr_trig_e;
endpackage

// *** src/tcsr_ext_irq_if.sv ***
// connection between the register and one external interrupt detector
`timescale 1ns/1ps
interface tcsr_ext_irq_if;
  logic pin;
  logic polarity;
  tcsr_pkg::tcsr_trig_e type_sel;
  logic vector;
  logic sw_wr;
  logic sw_val;
  logic pending;
  logic active;
  modport ctrl (
    output pin,
    output polarity,
    output type_sel,
    output vector,
    output sw_wr,
    output sw_val,
    input pending,
    input active
  );
  modport det (
    input pin,
    input polarity,
    input type_sel,
    input vector,
    input sw_wr,
    input sw_val,
    output pending,
    output active
  );
endinterface

// *** src/tcsr_ext_irq_det.sv ***
// external interrupt detector holding one pending flag
`timescale 1ns/1ps
`include "tcsr_defs.svh"
module tcsr_ext_irq_det (
  input wire logic clk,
  input wire logic rst,
  tcsr_ext_irq_if.det irq
);
  logic pending_q;
  logic pending_d;
  logic prev_q;
  logic prev_d;
  logic act;
  logic edge_hit;

  // ==========================================
  // polarity applied before type selection
  // R6 polarity before type
  // R7 polarity before type
  assign act = irq.polarity ? irq.pin : ~irq.pin;
  assign edge_hit = act & ~prev_q;
  assign irq.active = act;
  assign irq.pending = pending_q;

  // next flag value
  always_comb begin
    prev_d = act;
    pending_d = pending_q;
    // R3 level or edge
    // R4 level or edge
    if (irq.type_sel == tcsr_pkg::TCSR_LEVEL) begin
      pending_d = act; // follows the active level
    end else begin
      // R5 clear on vector
      // R10 set on event
      if (irq.sw_wr) begin
        pending_d = irq.sw_val;
      end
      if (irq.vector) begin
        pending_d = 1'b0;
      end
      if (edge_hit) begin
        pending_d = 1'b1; // set wins over clear
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_q <= 1'b0;
      prev_q <= `TCSR_PREV_RESET;
    end else begin
      pending_q <= pending_d;
      prev_q <= prev_d;
    end
  end

  // ==========================================
  // checks
  property p_level_follows;
    @(posedge clk) disable iff (rst)
    (irq.type_sel == tcsr_pkg::TCSR_LEVEL) |=> (pending_q == $past(act));
  endproperty
  a_level_follows: assert property (p_level_follows) // R3
    else $error("level mode flag does not follow input");

  property p_low_active;
    @(posedge clk) disable iff (rst)
    (irq.type_sel == tcsr_pkg::TCSR_LEVEL && !irq.polarity && !irq.pin) |=> pending_q;
  endproperty
  a_low_active: assert property (p_low_active) // R6
    else $error("active low level not flagged");

  property p_edge_sets;
    @(posedge clk) disable iff (rst)
    (irq.type_sel == tcsr_pkg::TCSR_EDGE && !prev_q && act) |=> pending_q;
  endproperty
  a_edge_sets: assert property (p_edge_sets) // R10
    else $error("active edge did not set flag");

  property p_edge_vector_clear;
    @(posedge clk) disable iff (rst)
    (irq.type_sel == tcsr_pkg::TCSR_EDGE && irq.vector && !edge_hit) |=> !pending_q;
  endproperty
  a_edge_vector_clear: assert property (p_edge_vector_clear) // R5
    else $error("vectoring did not clear edge flag");

  property p_edge_holds;
    @(posedge clk) disable iff (rst)
    (irq.type_sel == tcsr_pkg::TCSR_EDGE && pending_q && !irq.vector && !irq.sw_wr)
      |=> pending_q;
  endproperty
  a_edge_holds: assert property (p_edge_holds) // R4
    else $error("edge flag dropped without clear");

  c_edge_vector: cover property (@(posedge clk) disable iff (rst)
    edge_hit ##[1:20] irq.vector);
  c_level_active: cover property (@(posedge clk) disable iff (rst)
    (irq.type_sel == tcsr_pkg::TCSR_LEVEL) && act);
endmodule

// *** src/tcsr_timer_ctrl_status.sv ***
// timer control and status register with overflow and external interrupt flags
//
// Operation
// R1 - timer b overflow sets bit 7, vector clears
// R2 - timer a overflow sets bit 5, vector clears
// R3 - bit 2 selects level or edge, ext b
// R4 - bit 0 selects level or edge, ext a
// R5 - edge mode: vectoring clears ext b pending
// R6 - ext b polarity applied before type select
// R7 - ext a polarity applied before type select
// R8 - timer a runs: run bit and gate
// R9 - split mode: high byte uses timer b bits
// R10 - ext a pending set on event, cleared
`timescale 1ns/1ps
`include "tcsr_defs.svh"
module tcsr_timer_ctrl_status (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_RD,
  input wire logic SFR_BIT_WR,
  input wire logic [7:0] SFR_BIT_ADDR,
  input wire logic SFR_BIT_VAL,
  output logic [7:0] SFR_RDATA,
  input wire logic TIMER_A_OVF,
  input wire logic TIMER_B_OVF,
  input wire logic TIMER_A_SPLIT,
  input wire logic TIMER_A_HIGH_BYTE_OVF,
  input wire logic TIMER_A_GATE_ENABLE,
  input wire logic TIMER_B_GATE_ENABLE,
  input wire logic VECTOR_TIMER_A,
  input wire logic VECTOR_TIMER_B,
  input wire logic VECTOR_EXT_IRQ_A,
  input wire logic VECTOR_EXT_IRQ_B,
  input wire logic EXT_IRQ_A_INPUT,
  input wire logic EXT_IRQ_B_INPUT,
  input wire logic EXT_IRQ_A_POLARITY,
  input wire logic EXT_IRQ_B_POLARITY,
  output logic TIMER_A_COUNT_EN,
  output logic TIMER_A_HIGH_BYTE_COUNT_EN,
  output logic TIMER_B_COUNT_EN,
  output logic TIMER_A_OVERFLOW_FLAG,
  output logic TIMER_B_OVERFLOW_FLAG,
  output logic EXT_IRQ_A_PENDING,
  output logic EXT_IRQ_B_PENDING
);
  logic timer_a_overflow_flag_q;
  logic timer_a_overflow_flag_d;
  logic timer_b_overflow_flag_q;
  logic timer_b_overflow_flag_d;
  logic timer_a_run_q;
  logic timer_a_run_d;
  logic timer_b_run_q;
  logic timer_b_run_d;
  tcsr_pkg::tcsr_trig_e ext_irq_a_type_sel_q;
  tcsr_pkg::tcsr_trig_e ext_irq_a_type_sel_d;
  tcsr_pkg::tcsr_trig_e ext_irq_b_type_sel_q;
  tcsr_pkg::tcsr_trig_e ext_irq_b_type_sel_d;
  tcsr_pkg::tcsr_byte_t rdata_q;
  tcsr_pkg::tcsr_byte_t rdata_d;
  tcsr_pkg::tcsr_byte_t reg_view;
  logic byte_wr;
  logic bit_wr;
  logic set_b;

  tcsr_ext_irq_if irq_a ();
  tcsr_ext_irq_if irq_b ();

  // ==========================================
  // bus decode
  assign byte_wr = SFR_WR && (SFR_ADDR == `TCSR_ADDR);
  assign bit_wr = SFR_BIT_WR &&
    (SFR_BIT_ADDR[`TCSR_BITADDR_HI] == 5'(`TCSR_ADDR >> 3)); // upper five address bits

  // true when bit idx is written by a byte or a bit access
  function automatic logic wr_hit(input logic [2:0] idx);
    return byte_wr || (bit_wr && (SFR_BIT_ADDR[`TCSR_BITSEL_LO] == idx));
  endfunction

  // value written to bit idx
  function automatic logic wr_val(input logic [2:0] idx);
    return byte_wr ? SFR_WDATA[idx] : SFR_BIT_VAL;
  endfunction

  // ==========================================
  // external interrupt detectors
  assign irq_a.pin = EXT_IRQ_A_INPUT;
  assign irq_a.polarity = EXT_IRQ_A_POLARITY;
  assign irq_a.type_sel = ext_irq_a_type_sel_q;
  assign irq_a.vector = VECTOR_EXT_IRQ_A;
  assign irq_a.sw_wr = wr_hit(`TCSR_IE_A);
  assign irq_a.sw_val = wr_val(`TCSR_IE_A);
  assign irq_b.pin = EXT_IRQ_B_INPUT;
  assign irq_b.polarity = EXT_IRQ_B_POLARITY;
  assign irq_b.type_sel = ext_irq_b_type_sel_q;
  assign irq_b.vector = VECTOR_EXT_IRQ_B;
  assign irq_b.sw_wr = wr_hit(`TCSR_IE_B);
  assign irq_b.sw_val = wr_val(`TCSR_IE_B);

  tcsr_ext_irq_det u_det_a (
    .clk(CLK_SYS),
    .rst(RESET),
    .irq(irq_a.det)
  );

  tcsr_ext_irq_det u_det_b (
    .clk(CLK_SYS),
    .rst(RESET),
    .irq(irq_b.det)
  );

  // ==========================================
  // register view
  always_comb begin
    reg_view = `TCSR_RESET;
    reg_view[`TCSR_TF_B] = timer_b_overflow_flag_q;
    reg_view[`TCSR_TR_B] = timer_b_run_q;
    reg_view[`TCSR_TF_A] = timer_a_overflow_flag_q;
    reg_view[`TCSR_TR_A] = timer_a_run_q;
    reg_view[`TCSR_IE_B] = irq_b.pending;
    reg_view[`TCSR_IT_B] = ext_irq_b_type_sel_q;
    reg_view[`TCSR_IE_A] = irq_a.pending;
    reg_view[`TCSR_IT_A] = ext_irq_a_type_sel_q;
  end

  // R9 split overflow source
  assign set_b = TIMER_A_SPLIT ? TIMER_A_HIGH_BYTE_OVF : TIMER_B_OVF;

  // next register values
  always_comb begin
    timer_a_overflow_flag_d = timer_a_overflow_flag_q;
    timer_b_overflow_flag_d = timer_b_overflow_flag_q;
    timer_a_run_d = timer_a_run_q;
    timer_b_run_d = timer_b_run_q;
    ext_irq_a_type_sel_d = ext_irq_a_type_sel_q;
    ext_irq_b_type_sel_d = ext_irq_b_type_sel_q;
    rdata_d = `TCSR_RESET;
    if (wr_hit(`TCSR_TF_A)) begin
      timer_a_overflow_flag_d = wr_val(`TCSR_TF_A);
    end
    if (wr_hit(`TCSR_TF_B)) begin
      timer_b_overflow_flag_d = wr_val(`TCSR_TF_B);
    end
    if (wr_hit(`TCSR_TR_A)) begin
      timer_a_run_d = wr_val(`TCSR_TR_A);
    end
    if (wr_hit(`TCSR_TR_B)) begin
      timer_b_run_d = wr_val(`TCSR_TR_B);
    end
    // R3 type select b
    if (wr_hit(`TCSR_IT_B)) begin
      ext_irq_b_type_sel_d = tcsr_pkg::tcsr_trig_e'(wr_val(`TCSR_IT_B));
    end
    // R4 type select a
    if (wr_hit(`TCSR_IT_A)) begin
      ext_irq_a_type_sel_d = tcsr_pkg::tcsr_trig_e'(wr_val(`TCSR_IT_A));
    end
    // R2 vector clear, overflow set
    if (VECTOR_TIMER_A) begin
      timer_a_overflow_flag_d = 1'b0;
    end
    if (TIMER_A_OVF) begin
      timer_a_overflow_flag_d = 1'b1;
    end
    // R1 vector clear, overflow set
    if (VECTOR_TIMER_B) begin
      timer_b_overflow_flag_d = 1'b0;
    end
    if (set_b) begin
      timer_b_overflow_flag_d = 1'b1;
    end
    if (SFR_RD && (SFR_ADDR == `TCSR_ADDR)) begin
      rdata_d = reg_view;
    end
  end

  // registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      timer_a_overflow_flag_q <= 1'b0;
      timer_b_overflow_flag_q <= 1'b0;
      timer_a_run_q <= 1'b0;
      timer_b_run_q <= 1'b0;
      ext_irq_a_type_sel_q <= tcsr_pkg::TCSR_LEVEL;
      ext_irq_b_type_sel_q <= tcsr_pkg::TCSR_LEVEL;
      rdata_q <= `TCSR_RESET;
    end else begin
      timer_a_overflow_flag_q <= timer_a_overflow_flag_d;
      timer_b_overflow_flag_q <= timer_b_overflow_flag_d;
      timer_a_run_q <= timer_a_run_d;
      timer_b_run_q <= timer_b_run_d;
      ext_irq_a_type_sel_q <= ext_irq_a_type_sel_d;
      ext_irq_b_type_sel_q <= ext_irq_b_type_sel_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // outputs
  // R8 run and gate
  assign TIMER_A_COUNT_EN = timer_a_run_q && (!TIMER_A_GATE_ENABLE || irq_a.active);
  // R9 high byte under timer b run
  assign TIMER_A_HIGH_BYTE_COUNT_EN = TIMER_A_SPLIT && timer_b_run_q;
  assign TIMER_B_COUNT_EN = timer_b_run_q && (!TIMER_B_GATE_ENABLE || irq_b.active);
  assign TIMER_A_OVERFLOW_FLAG = timer_a_overflow_flag_q;
  assign TIMER_B_OVERFLOW_FLAG = timer_b_overflow_flag_q;
  assign EXT_IRQ_A_PENDING = irq_a.pending;
  assign EXT_IRQ_B_PENDING = irq_b.pending;
  assign SFR_RDATA = rdata_q;

  // ==========================================
  // checks
  property p_tfb_set;
    @(posedge CLK_SYS) disable iff (RESET)
    (TIMER_B_OVF && !TIMER_A_SPLIT) |=> TIMER_B_OVERFLOW_FLAG;
  endproperty
  a_tfb_set: assert property (p_tfb_set) // R1
    else $error("timer b overflow did not set flag");

  property p_tfb_vector;
    @(posedge CLK_SYS) disable iff (RESET)
    (VECTOR_TIMER_B && !set_b) |=> !TIMER_B_OVERFLOW_FLAG;
  endproperty
  a_tfb_vector: assert property (p_tfb_vector) // R1
    else $error("timer b vector did not clear flag");

  property p_tfa_set_hold;
    @(posedge CLK_SYS) disable iff (RESET)
    TIMER_A_OVF ##1 (!VECTOR_TIMER_A && !wr_hit(`TCSR_TF_A)) |->
      TIMER_A_OVERFLOW_FLAG [*2];
  endproperty
  a_tfa_set_hold: assert property (p_tfa_set_hold) // R2
    else $error("timer a flag not set and held");

  property p_tfa_vector;
    @(posedge CLK_SYS) disable iff (RESET)
    (VECTOR_TIMER_A && !TIMER_A_OVF) |=> !TIMER_A_OVERFLOW_FLAG;
  endproperty
  a_tfa_vector: assert property (p_tfa_vector) // R2
    else $error("timer a vector did not clear flag");

  property p_run_off;
    @(posedge CLK_SYS) disable iff (RESET)
    (wr_hit(`TCSR_TR_A) && !wr_val(`TCSR_TR_A)) |=> !TIMER_A_COUNT_EN;
  endproperty
  a_run_off: assert property (p_run_off) // R8
    else $error("timer a counts after run cleared");

  property p_gate_block;
    @(posedge CLK_SYS) disable iff (RESET)
    (TIMER_A_GATE_ENABLE && (EXT_IRQ_A_INPUT != EXT_IRQ_A_POLARITY)) |-> !TIMER_A_COUNT_EN;
  endproperty
  a_gate_block: assert property (p_gate_block) // R8
    else $error("gated timer a counts with input inactive");

  property p_split_set;
    @(posedge CLK_SYS) disable iff (RESET)
    (TIMER_A_SPLIT && TIMER_A_HIGH_BYTE_OVF) |=> TIMER_B_OVERFLOW_FLAG;
  endproperty
  a_split_set: assert property (p_split_set) // R9
    else $error("high byte overflow did not set timer b flag");

  property p_split_mask;
    @(posedge CLK_SYS) disable iff (RESET)
    (TIMER_A_SPLIT && TIMER_B_OVF && !TIMER_A_HIGH_BYTE_OVF && !TIMER_B_OVERFLOW_FLAG
      && !wr_hit(`TCSR_TF_B)) |=> !TIMER_B_OVERFLOW_FLAG;
  endproperty
  a_split_mask: assert property (p_split_mask) // R9
    else $error("timer b overflow set flag in split mode");

  property p_read;
    @(posedge CLK_SYS) disable iff (RESET)
    (SFR_RD && SFR_ADDR == `TCSR_ADDR) |=> (SFR_RDATA == $past(reg_view));
  endproperty
  a_read: assert property (p_read) // register read
    else $error("register read returned wrong value");

  c_tfa_cycle: cover property (@(posedge CLK_SYS) disable iff (RESET)
    TIMER_A_OVF ##[1:10] VECTOR_TIMER_A);
  c_split: cover property (@(posedge CLK_SYS) disable iff (RESET)
    TIMER_A_SPLIT && TIMER_A_HIGH_BYTE_OVF);
  c_gated_run: cover property (@(posedge CLK_SYS) disable iff (RESET)
    TIMER_A_GATE_ENABLE && TIMER_A_COUNT_EN);
endmodule

// *** verification/tcsr_cpu_model.sv ***
// cpu core model driving the register bus and interrupt vectors
`timescale 1ns/1ps
module tcsr_cpu_model (
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic sfr_rd,
  output logic sfr_bit_wr,
  output logic [7:0] sfr_bit_addr,
  output logic sfr_bit_val,
  input wire logic [7:0] sfr_rdata,
  output logic [3:0] vec
);
  // ==========================================
  // idle bus from time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
    sfr_bit_wr = 1'b0;
    sfr_bit_addr = 8'h00;
    sfr_bit_val = 1'b0;
    vec = 4'h0;
  end
  // released bus shows inverted values, never the last access
  task automatic release_bus();
    sfr_addr = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
    sfr_bit_addr = ~sfr_bit_addr;
    sfr_bit_val = ~sfr_bit_val;
  endtask
  // ==========================================
  // byte write, one cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    release_bus();
  endtask
  // byte read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    release_bus();
  endtask
  // single bit write
  task automatic bwr(input logic [7:0] a, input logic v);
    @(negedge clk);
    sfr_bit_addr = a;
    sfr_bit_val = v;
    sfr_bit_wr = 1'b1;
    @(negedge clk);
    sfr_bit_wr = 1'b0;
    release_bus();
  endtask
  // vector pulse: 0 timer a, 1 timer b, 2 ext a, 3 ext b
  task automatic vect(input int k);
    @(negedge clk);
    vec[k] = 1'b1;
    @(negedge clk);
    vec[k] = 1'b0;
  endtask
endmodule

// *** verification/tb_timer_control_status_reg.sv ***
// self-checking bench of the timer control and status register
`timescale 1ns/1ps
`include "tcsr_defs.svh"
module tb_timer_control_status_reg;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic split = 1'b0;
  logic hb_ovf = 1'b0;
  logic [1:0] ovf = 2'h0;
  logic [1:0] gate = 2'h0;
  logic [1:0] ext_in = 2'h0;
  logic [1:0] pol = 2'h3;
  logic [7:0] rv;
  wire [7:0] addr, wdata, baddr, rdata;
  wire wr, rd, bwr, bval, hb_cen;
  wire [3:0] vec;
  wire [1:0] cen, tflag, pend;
  int fail_count = 0;
  int total_checks = 0;
  // ==========================================
  // clock, 100 ns period
  always #50 clk_sys = ~clk_sys;
  tcsr_cpu_model cpu (
    .clk(clk_sys), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rd(rd),
    .sfr_bit_wr(bwr), .sfr_bit_addr(baddr), .sfr_bit_val(bval), .sfr_rdata(rdata), .vec(vec)
  );
  tcsr_timer_ctrl_status dut (
    .CLK_SYS(clk_sys), .RESET(reset), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_WDATA(wdata),
    .SFR_RD(rd), .SFR_BIT_WR(bwr), .SFR_BIT_ADDR(baddr), .SFR_BIT_VAL(bval),
    .SFR_RDATA(rdata), .TIMER_A_OVF(ovf[0]), .TIMER_B_OVF(ovf[1]), .TIMER_A_SPLIT(split),
    .TIMER_A_HIGH_BYTE_OVF(hb_ovf), .TIMER_A_GATE_ENABLE(gate[0]),
    .TIMER_B_GATE_ENABLE(gate[1]), .VECTOR_TIMER_A(vec[0]), .VECTOR_TIMER_B(vec[1]),
    .VECTOR_EXT_IRQ_A(vec[2]), .VECTOR_EXT_IRQ_B(vec[3]), .EXT_IRQ_A_INPUT(ext_in[0]),
    .EXT_IRQ_B_INPUT(ext_in[1]), .EXT_IRQ_A_POLARITY(pol[0]), .EXT_IRQ_B_POLARITY(pol[1]),
    .TIMER_A_COUNT_EN(cen[0]), .TIMER_A_HIGH_BYTE_COUNT_EN(hb_cen),
    .TIMER_B_COUNT_EN(cen[1]), .TIMER_A_OVERFLOW_FLAG(tflag[0]),
    .TIMER_B_OVERFLOW_FLAG(tflag[1]), .EXT_IRQ_A_PENDING(pend[0]),
    .EXT_IRQ_B_PENDING(pend[1])
  );
  // ==========================================
  // compare and verdict helpers
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    cpu.rd(a, rv);
    chk(name, rv, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse_ovf(input int i);
    @(negedge clk_sys);
    ovf[i] = 1'b1;
    @(negedge clk_sys);
    ovf[i] = 1'b0;
  endtask
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end
  // main sequence
  initial begin
    tick(3);
    reset = 1'b0;
    tick(1);
    chk("count enables", 8'({hb_cen, cen}), 8'h00);
    chk("flags", 8'({tflag, pend}), 8'h00);
    rchk("reset value", `TCSR_ADDR, `TCSR_RESET);
    tick(1);
    chk("read data idle", rdata, 8'h00);
    cpu.wr(`TCSR_ADDR, 8'h55);
    rchk("byte readback", `TCSR_ADDR, 8'h55);
    cpu.wr(`TCSR_ADDR, 8'haa);
    rchk("level pending write", `TCSR_ADDR, 8'ha0);
    cpu.wr(8'h89, 8'hff);
    cpu.bwr(8'h90, 1'b1);
    rchk("unmapped write", `TCSR_ADDR, 8'ha0);
    rchk("unmapped read", 8'h89, 8'h00);
    cpu.wr(`TCSR_ADDR, 8'h00);
    // overflow set, vector and software clear
    for (int i = 0; i < 2; i++) begin
      pulse_ovf(i);
      chk("flag set", 8'(tflag[i]), 8'h01);
      rchk("flag in register", `TCSR_ADDR, 8'h20 << (2 * i));
      cpu.vect(1 - i);
      chk("other vector", 8'(tflag[i]), 8'h01);
      cpu.vect(i);
      chk("flag after vector", 8'(tflag[i]), 8'h00);
      pulse_ovf(i);
      cpu.bwr(8'h8d + 8'(2 * i), 1'b0);
      chk("flag software clear", 8'(tflag[i]), 8'h00);
      fork
        pulse_ovf(i);
        cpu.vect(i);
      join
      chk("set beats vector", 8'(tflag[i]), 8'h01);
      cpu.wr(`TCSR_ADDR, 8'h00);
    end
    // split mode hands bit 7 to the high byte
    split = 1'b1;
    pulse_ovf(1);
    chk("split ignores timer b", 8'(tflag[1]), 8'h00);
    chk("high byte idle", 8'(hb_cen), 8'h00);
    @(negedge clk_sys);
    hb_ovf = 1'b1;
    @(negedge clk_sys);
    hb_ovf = 1'b0;
    chk("high byte overflow", 8'(tflag[1]), 8'h01);
    cpu.wr(`TCSR_ADDR, 8'h40);
    chk("high byte run", 8'(hb_cen), 8'h01);
    split = 1'b0;
    tick(1);
    chk("high byte stopped", 8'(hb_cen), 8'h00);
    cpu.wr(`TCSR_ADDR, 8'h00);
    // gate, level and edge modes of both inputs
    for (int c = 0; c < 2; c++) begin
      cpu.wr(`TCSR_ADDR, 8'h10 << (2 * c));
      chk("run without gate", 8'(cen[c]), 8'h01);
      gate[c] = 1'b1;
      tick(1);
      chk("gate inactive", 8'(cen[c]), 8'h00);
      ext_in[c] = 1'b1;
      tick(2);
      chk("gate active", 8'(cen[c]), 8'h01);
      chk("level pending", 8'(pend[c]), 8'h01);
      cpu.vect(2 + c);
      cpu.bwr(8'h89 + 8'(2 * c), 1'b0);
      chk("level pending held", 8'(pend[c]), 8'h01);
      pol[c] = 1'b0;
      tick(2);
      chk("polarity on level", 8'(pend[c]), 8'h00);
      chk("polarity on gate", 8'(cen[c]), 8'h00);
      ext_in[c] = 1'b0;
      tick(2);
      chk("active low level", 8'(pend[c]), 8'h01);
      ext_in[c] = 1'b1;
      tick(1);
      cpu.wr(`TCSR_ADDR, 8'h01 << (2 * c));
      chk("edge idle", 8'(pend[c]), 8'h00);
      ext_in[c] = 1'b0;
      tick(2);
      chk("falling edge", 8'(pend[c]), 8'h01);
      ext_in[c] = 1'b1;
      tick(2);
      chk("edge flag held", 8'(pend[c]), 8'h01);
      cpu.vect(2 + c);
      chk("edge vector clear", 8'(pend[c]), 8'h00);
      ext_in[c] = 1'b0;
      pol[c] = 1'b1;
      tick(1);
      ext_in[c] = 1'b1;
      tick(2);
      chk("rising edge", 8'(pend[c]), 8'h01);
      cpu.bwr(8'h89 + 8'(2 * c), 1'b0);
      chk("software clear", 8'(pend[c]), 8'h00);
      cpu.bwr(8'h89 + 8'(2 * c), 1'b1);
      chk("software set", 8'(pend[c]), 8'h01);
      cpu.wr(`TCSR_ADDR, 8'h00);
      gate[c] = 1'b0;
      ext_in[c] = 1'b0;
      tick(2);
    end
    finish_test();
  end
endmodule
